// ### inc/rsc_pkg.sv
// Purpose: shared constants and types of the reset source controller
// Assumes: 125 MHz MCLK, 32-bit Avalon-MM register window
// Notes: offsets are byte addresses, one aligned word per register
package rsc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] RSC_OFS_CAUSE = 8'h00;
  localparam logic [7:0] RSC_OFS_LEVEL = 8'h04;
  localparam logic [7:0] RSC_OFS_DETCTL = 8'h08;
  localparam logic [7:0] RSC_OFS_PORTCTL = 8'h0C;
  localparam logic [7:0] RSC_OFS_STATUS = 8'h10;
  localparam logic [7:0] RSC_OFS_PCVAL = 8'h14;

  // cause flag positions
  localparam int RSC_BIT_TRAP = 7;
  localparam int RSC_BIT_WDOG = 4;
  localparam int RSC_BIT_INIT = 1;
  localparam int RSC_BIT_UVOLT = 0;

  // reset values
  localparam logic [7:0] RSC_CAUSE_RST = 8'h00;
  localparam logic [7:0] RSC_LEVEL_RST = 8'h0E;
  localparam logic [7:0] RSC_DETCTL_RST = 8'h00;
  localparam logic [7:0] RSC_DETCTL_OPT = 8'h80;
  localparam logic [7:0] RSC_PORT_LATCH_RST = 8'h00;
  localparam logic [7:0] RSC_IRQ_MASK_RST = 8'hFF;
  localparam logic [15:0] RSC_TIMER_CNT_RST = 16'hFFFF;
  localparam logic [15:0] RSC_SERIAL_OP_RST = 16'h0087;
  localparam logic [7:0] RSC_ANALOG_CFG_RST = 8'h10;

  // instruction code and vector addresses
  localparam logic [7:0] RSC_ILLEGAL_OP = 8'hFF;
  localparam logic [15:0] RSC_VEC_LO_ADDR = 16'h0000;
  localparam logic [15:0] RSC_VEC_HI_ADDR = 16'h0001;

  // reset processing time
  localparam int RSC_CLK_MHZ = 125;
  localparam int RSC_PROC_NS = 500;
  localparam int RSC_PROC_CYC = (RSC_PROC_NS * RSC_CLK_MHZ + 999) / 1000;

  // sequencer states
  typedef enum logic [2:0] {
    RSC_ST_RESET,
    RSC_ST_PROC,
    RSC_ST_FETCH_LO,
    RSC_ST_FETCH_HI,
    RSC_ST_LOAD,
    RSC_ST_RUN
  } rsc_state_t;

  // control levels towards clocks, core and peripherals
  typedef struct packed {
    logic sys_rst;
    logic core_clk_stop;
    logic periph_stop;
    logic wdt_clr;
    logic xtal_stop;
    logic xtal_pins_in;
    logic sub_osc_stop;
    logic ext_clk_ignore;
    logic poc_en;
    logic lvd_en;
    logic ram_keep;
    logic pc_valid;
    logic ihs_clk_sel;
  } rsc_ctl_t;

  // initial values handed to peripherals
  typedef struct packed {
    logic [7:0] port_latch;
    logic [7:0] irq_mask;
    logic [15:0] timer_cnt;
    logic [15:0] serial_op;
    logic [7:0] analog_cfg;
  } rsc_init_t;

endpackage

// ### rtl/rsc_sync.sv
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, no bus coherency needed
// Notes: first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module rsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // two stages, reset to a constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### rtl/rsc_top.sv
// Purpose: reset source controller, combines reset requests and sequences release
// Assumes: vector memory answers one cycle after VEC_RD
// Notes: registers reached over Avalon-MM with waitrequest
//
// Functional notes
// R1: in reset the indicator pin drives low, all other port pins float
// R2: indicator pin stays low until software writes it high
// R3: a watchdog reset also clears the watchdog timer
// R4: reset stops core clock, flash, timers, serial, converter and DMA
// R5: reset stops main and sub oscillators, pins input, external clock ignored
// R6: working memory kept unless supply fell below power-on-clear level; code keeps it only on a reset taken while STANDBY is high
// R7: power-on-clear runs in reset; undervoltage detector only on its own reset
// R8: program counter loads from vector bytes at addresses 0 and 1
// R9: in reset only the program counter is undefined
// R10: reset from standby keeps data memory and general registers
// R11: pin and power-on-clear clear all flags; others set only their own
// R12: cause flag register resets to zero, flags follow the source
// R13: level select resets to default except on undervoltage reset
// R14: detector control resets to zero, varied by source and option
// R15: port output latches cleared on reset
// R16: interrupt mask flags set to all ones on reset
// R17: timer counters set to all ones on reset
// R18: serial operation setting registers take their non-zero default
// R19: analog pin configuration takes its non-zero default
// R20: after pin release, processing ends and run starts on internal clock
// R21: executing the all-ones opcode raises an illegal instruction reset
// R22: reading the cause flags clears all four; code clears only the flags that the read reported
// R23: all requests merge into one reset held until last one ends
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
#(
  parameter int PROC_CYC = RSC_PROC_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // asynchronous reset sources
  input wire logic RESET_N_PIN,
  input wire logic POC_DET,
  input wire logic LVD_DET,
  // same-clock reset sources
  input wire logic WDT_OVF,
  input wire logic INIT_ERR,
  input wire logic [7:0] OPCODE,
  input wire logic OPCODE_VALID,
  input wire logic STANDBY,
  input wire logic OPT_LVD_ON,
  // reset vector fetch
  output logic VEC_RD,
  output logic [15:0] VEC_ADDR,
  input wire logic [7:0] VEC_RDATA,
  output logic PC_LOAD,
  output logic [15:0] PC_VALUE,
  // controls and initial values
  output var rsc_ctl_t CTL,
  output var rsc_init_t INIT,
  // pins
  output logic IND_PIN_O,
  output logic IND_PIN_OE,
  output logic PINS_HIZ,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  localparam logic [15:0] PROC_LAST = 16'(PROC_CYC - 1);

  rsc_state_t state_q, state_d;
  logic [15:0] cnt_q;
  logic [7:0] cause_q, level_q, detctl_q;
  logic [7:0] pc_lo_q;
  logic lvd_keep_q, ram_keep_q, ind_q;
  logic [2:0] sync_w;

  // pin and analog detector levels into the clock domain
  rsc_sync #(.W(3), .RST_VAL(3'b001)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d({POC_DET, LVD_DET, RESET_N_PIN}),
    .q(sync_w)
  );

  // request decode
  wire ext_req = !sync_w[0];
  wire lvd_req = sync_w[1];
  wire poc_req = sync_w[2];
  // R21: all-ones opcode
  wire ill_req = OPCODE_VALID && (OPCODE == RSC_ILLEGAL_OP);
  wire clr_req = ext_req || poc_req;
  wire nonlvd_req = clr_req || WDT_OVF || INIT_ERR || ill_req;
  // R23: merged request
  wire any_req = nonlvd_req || lvd_req;
  wire run_d = (state_d == RSC_ST_RUN);

  // bus decode
  wire bus_req = AVS_READ || AVS_WRITE;
  wire bus_fire = bus_req && !AVS_WAITREQUEST;
  wire wr_fire = bus_fire && AVS_WRITE && AVS_BYTEENABLE[0];
  wire rd_cause = bus_fire && AVS_READ && (AVS_ADDRESS == RSC_OFS_CAUSE);
  wire wr_level = wr_fire && (AVS_ADDRESS == RSC_OFS_LEVEL);
  wire wr_detctl = wr_fire && (AVS_ADDRESS == RSC_OFS_DETCTL);
  wire wr_port = wr_fire && (AVS_ADDRESS == RSC_OFS_PORTCTL);

  // cause flag update, set wins over clear
  wire [7:0] cause_set = (8'(ill_req) << RSC_BIT_TRAP) | (8'(WDT_OVF) << RSC_BIT_WDOG)
                         | (8'(INIT_ERR) << RSC_BIT_INIT) | (8'(lvd_req) << RSC_BIT_UVOLT);
  // R22: read clears only what was reported
  wire [7:0] cause_clr = rd_cause ? AVS_READDATA[7:0] : 8'h00;
  // R11: pin and power-on-clear wipe all, others set own
  wire [7:0] cause_d = (clr_req ? 8'h00 : (cause_q & ~cause_clr)) | cause_set;
  wire [7:0] detctl_dflt = OPT_LVD_ON ? (RSC_DETCTL_RST | RSC_DETCTL_OPT) : RSC_DETCTL_RST;

  // read mux
  wire [7:0] status_w = {5'h00, lvd_keep_q, ram_keep_q, state_q != RSC_ST_RUN};
  wire [31:0] rdata_w =
    (AVS_ADDRESS == RSC_OFS_CAUSE) ? {24'h00_0000, cause_q} :
    (AVS_ADDRESS == RSC_OFS_LEVEL) ? {24'h00_0000, level_q} :
    (AVS_ADDRESS == RSC_OFS_DETCTL) ? {24'h00_0000, detctl_q} :
    (AVS_ADDRESS == RSC_OFS_PORTCTL) ? {24'h00_0000, 7'h00, ind_q} :
    (AVS_ADDRESS == RSC_OFS_STATUS) ? {24'h00_0000, status_w} :
    (AVS_ADDRESS == RSC_OFS_PCVAL) ? {16'h0000, PC_VALUE} : 32'h0000_0000;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSC_ST_RESET: if (!any_req) state_d = RSC_ST_PROC;
      RSC_ST_PROC: if (cnt_q == PROC_LAST) state_d = RSC_ST_FETCH_LO;
      RSC_ST_FETCH_LO: state_d = RSC_ST_FETCH_HI;
      RSC_ST_FETCH_HI: state_d = RSC_ST_LOAD;
      RSC_ST_LOAD: state_d = RSC_ST_RUN;
      RSC_ST_RUN: state_d = RSC_ST_RUN;
    endcase
    // R23: any request restarts reset
    if (any_req) begin
      state_d = RSC_ST_RESET;
    end
  end

  // sequencer state and processing counter
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= RSC_ST_RESET;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == RSC_ST_PROC) ? cnt_q + 16'h0001 : 16'h0000;
    end
  end

  // R8: vector fetch, low byte then high byte
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      VEC_RD <= 1'b0;
      VEC_ADDR <= RSC_VEC_LO_ADDR;
      pc_lo_q <= 8'h00;
      PC_VALUE <= 16'h0000;
      PC_LOAD <= 1'b0;
    end else begin
      VEC_RD <= (state_d == RSC_ST_FETCH_LO) || (state_d == RSC_ST_FETCH_HI);
      VEC_ADDR <= (state_d == RSC_ST_FETCH_HI) ? RSC_VEC_HI_ADDR : RSC_VEC_LO_ADDR;
      if (state_q == RSC_ST_FETCH_HI) pc_lo_q <= VEC_RDATA;
      if (state_q == RSC_ST_LOAD && run_d) PC_VALUE <= {VEC_RDATA, pc_lo_q};
      PC_LOAD <= (state_q == RSC_ST_LOAD) && run_d;
    end
  end

  // R12: cause flags start at zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cause_q <= RSC_CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // R13: level select default except undervoltage; R14: detector control
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      level_q <= RSC_LEVEL_RST;
      detctl_q <= RSC_DETCTL_RST;
    end else if (nonlvd_req) begin
      level_q <= RSC_LEVEL_RST;
      detctl_q <= detctl_dflt;
    end else begin
      if (wr_level) level_q <= AVS_WRITEDATA[7:0];
      if (wr_detctl) detctl_q <= AVS_WRITEDATA[7:0];
    end
  end

  // R7: detector keeps running only through its own reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lvd_keep_q <= 1'b0;
    end else if (lvd_req) begin
      lvd_keep_q <= 1'b1;
    end else if (nonlvd_req || state_q == RSC_ST_RUN) begin
      lvd_keep_q <= 1'b0;
    end
  end

  // R6: memory lost below power-on-clear; R10: standby entry keeps it
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ram_keep_q <= 1'b0;
    end else if (poc_req) begin
      ram_keep_q <= 1'b0;
    end else if (state_q == RSC_ST_RUN && any_req) begin
      ram_keep_q <= STANDBY;
    end
  end

  // R1: indicator latch forced low in reset; R2: software raises it
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ind_q <= 1'b0;
      IND_PIN_O <= 1'b0;
      IND_PIN_OE <= 1'b1;
      PINS_HIZ <= 1'b1;
    end else begin
      ind_q <= run_d && (wr_port ? AVS_WRITEDATA[0] : ind_q);
      IND_PIN_O <= run_d && (wr_port ? AVS_WRITEDATA[0] : ind_q);
      IND_PIN_OE <= 1'b1;
      PINS_HIZ <= !run_d;
    end
  end

  // clock, peripheral and oscillator controls, registered
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CTL <= '{sys_rst: 1'b1, core_clk_stop: 1'b1, periph_stop: 1'b1, wdt_clr: 1'b1,
               xtal_stop: 1'b1, xtal_pins_in: 1'b1, sub_osc_stop: 1'b1, ext_clk_ignore: 1'b1,
               poc_en: 1'b1, lvd_en: 1'b0, ram_keep: 1'b0, pc_valid: 1'b0, ihs_clk_sel: 1'b1};
    end else begin
      // R4: core clock and peripherals halted
      CTL.sys_rst <= !run_d;
      CTL.core_clk_stop <= !run_d;
      CTL.periph_stop <= !run_d;
      // R3: watchdog cleared by every reset, its own included
      CTL.wdt_clr <= !run_d || WDT_OVF;
      // R5: oscillators stopped and pins to input mode
      CTL.xtal_stop <= !run_d;
      CTL.xtal_pins_in <= !run_d;
      CTL.sub_osc_stop <= !run_d;
      CTL.ext_clk_ignore <= !run_d;
      CTL.poc_en <= 1'b1;
      CTL.lvd_en <= run_d || lvd_req || (lvd_keep_q && !nonlvd_req);
      CTL.ram_keep <= ram_keep_q && !poc_req;
      // R9: only the program counter is undefined
      CTL.pc_valid <= run_d;
      // R20: run starts on internal high-speed clock
      CTL.ihs_clk_sel <= !run_d || CTL.ihs_clk_sel;
    end
  end

  // R15 R16 R17 R18 R19: peripheral reset values
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      INIT <= '{port_latch: RSC_PORT_LATCH_RST, irq_mask: RSC_IRQ_MASK_RST,
                timer_cnt: RSC_TIMER_CNT_RST, serial_op: RSC_SERIAL_OP_RST,
                analog_cfg: RSC_ANALOG_CFG_RST};
    end else begin
      INIT <= '{port_latch: RSC_PORT_LATCH_RST, irq_mask: RSC_IRQ_MASK_RST,
                timer_cnt: RSC_TIMER_CNT_RST, serial_op: RSC_SERIAL_OP_RST,
                analog_cfg: RSC_ANALOG_CFG_RST};
    end
  end

  // avalon slave: one wait cycle, then answer
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= !(bus_req && AVS_WAITREQUEST);
      if (bus_req && AVS_WAITREQUEST) AVS_READDATA <= AVS_READ ? rdata_w : 32'h0000_0000;
    end
  end

  // checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  pin_low_a: assert property ((state_q != RSC_ST_RUN) |-> (!IND_PIN_O && PINS_HIZ && IND_PIN_OE)) // R1
    else $error("indicator pin not low or ports not floating in reset");
  wdt_clear_a: assert property (WDT_OVF |=> (CTL.wdt_clr && state_q == RSC_ST_RESET)) // R3
    else $error("watchdog not cleared on its own reset");
  clk_stop_a: assert property ((state_q != RSC_ST_RUN) |-> (CTL.core_clk_stop && CTL.periph_stop)) // R4
    else $error("core clock or peripherals running in reset");
  osc_stop_a: assert property ($fell(state_q == RSC_ST_RUN) |-> // R5
    (CTL.xtal_stop && CTL.xtal_pins_in && CTL.sub_osc_stop && CTL.ext_clk_ignore))
    else $error("oscillators not stopped at reset entry");
  lvd_run_a: assert property ((lvd_req && !nonlvd_req) |=> CTL.lvd_en) // R7
    else $error("detector stopped during its own reset");
  vector_load_a: assert property (PC_LOAD |-> // R8
    (PC_VALUE == {$past(VEC_RDATA), $past(VEC_RDATA, 2)} && state_q == RSC_ST_RUN))
    else $error("program counter not loaded from vector bytes");
  pc_invalid_a: assert property ((state_q != RSC_ST_RUN) |-> !CTL.pc_valid) // R9
    else $error("program counter marked valid in reset");
  cause_clear_a: assert property ((clr_req && cause_set == 8'h00) |=> (cause_q == 8'h00)) // R11
    else $error("pin or power-on-clear did not clear cause flags");
  cause_own_a: assert property ((WDT_OVF && !clr_req) |=> // R11
    (cause_q[RSC_BIT_WDOG] && (cause_q[RSC_BIT_TRAP] == $past(cause_q[RSC_BIT_TRAP]) || $past(ill_req))))
    else $error("watchdog reset disturbed another flag");
  level_dflt_a: assert property (nonlvd_req |=> (level_q == RSC_LEVEL_RST)) // R13
    else $error("level select not restored to default");
  read_clear_a: assert property ((rd_cause && !any_req) |=> ((cause_q & $past(AVS_READDATA[7:0])) == 8'h00)) // R22
    else $error("cause read did not clear flags");
  merge_hold_a: assert property (any_req |=> (state_q == RSC_ST_RESET && CTL.sys_rst)) // R23
    else $error("reset released while a request is active");
  proc_wait_a: assert property ($rose(state_q == RSC_ST_FETCH_LO) |-> // R20
    ($past(state_q) == RSC_ST_PROC && $past(cnt_q) == PROC_LAST))
    else $error("reset processing cut short");

endmodule
`default_nettype wire

// ### tb/rsc_vec_mem.sv
// Purpose: vector memory model on the fetch port
// Assumes: byte answered one cycle after a read request
// Notes: bus shows a changing pattern when not read
`timescale 1ns/10ps
`default_nettype none
module rsc_vec_mem #(
  parameter logic [7:0] LO = 8'hA1,
  parameter logic [7:0] HI = 8'hB2
) (
  // clock
  input wire logic MCLK,
  // fetch port
  input wire logic VEC_RD,
  input wire logic [15:0] VEC_ADDR,
  output logic [7:0] VEC_RDATA
);
  logic [7:0] data_q = 8'h5A;
  assign VEC_RDATA = data_q;
  // addressed byte, else inverted junk so stale data never matches
  always @(posedge MCLK) begin
    if (VEC_RD) begin
      data_q <= (VEC_ADDR == 16'h0001) ? HI : ((VEC_ADDR == 16'h0000) ? LO : 8'h00);
    end else begin
      data_q <= ~data_q;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_rsc_top.sv
// Purpose: self-checking bench of the reset source controller
// Assumes: short processing count, vector model on the fetch port
// Notes: each scenario task judges its own results
`timescale 1ns/10ps
`default_nettype none
module tb_rsc_top;
  import rsc_pkg::*;
  localparam int PROC = 4;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic RESET_N_PIN = 1'b1;
  logic POC_DET = 1'b0;
  logic LVD_DET = 1'b0;
  logic WDT_OVF = 1'b0;
  logic INIT_ERR = 1'b0;
  logic [7:0] OPCODE = 8'h00;
  logic OPCODE_VALID = 1'b0;
  logic STANDBY = 1'b0;
  logic OPT_LVD_ON = 1'b0;
  logic VEC_RD, PC_LOAD, IND_PIN_O, IND_PIN_OE, PINS_HIZ, AVS_WAITREQUEST;
  logic [15:0] VEC_ADDR, PC_VALUE;
  logic [7:0] VEC_RDATA;
  rsc_ctl_t CTL;
  rsc_init_t INIT;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE = 4'h1;
  logic [31:0] AVS_READDATA, rd;
  int errors = 0;
  int num_checks = 0;

  rsc_top #(.PROC_CYC(PROC)) u_rsc_top (.MCLK, .RST, .RESET_N_PIN, .POC_DET, .LVD_DET, .WDT_OVF,
    .INIT_ERR, .OPCODE, .OPCODE_VALID, .STANDBY, .OPT_LVD_ON, .VEC_RD, .VEC_ADDR, .VEC_RDATA,
    .PC_LOAD, .PC_VALUE, .CTL, .INIT, .IND_PIN_O, .IND_PIN_OE, .PINS_HIZ, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST);
  rsc_vec_mem u_rsc_vec_mem (.MCLK, .VEC_RD, .VEC_ADDR, .VEC_RDATA);

  // 125 MHz clock
  always #4 MCLK = ~MCLK;

  // compare and count
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  // one bus access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    // wait for the answer; only the hang guard ends a hang
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge MCLK);
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd, exp, what);
  endtask

  // raise or drop one reset source
  task automatic drv(input int src, input logic on);
    case (src)
      0: RESET_N_PIN <= ~on;
      1: POC_DET <= on;
      2: LVD_DET <= on;
      3: WDT_OVF <= on;
      4: INIT_ERR <= on;
      default: begin
        OPCODE <= on ? 8'hFF : 8'h00;
        OPCODE_VALID <= on;
      end
    endcase
  endtask

  // levels that must stand while the reset holds
  task automatic in_reset(input logic lvd, input logic keep);
    cmp({IND_PIN_O, IND_PIN_OE, PINS_HIZ, CTL.sys_rst}, 4'h7, "pins in reset");
    cmp({CTL.core_clk_stop, CTL.periph_stop, CTL.wdt_clr}, 3'h7, "core stop");
    cmp({CTL.xtal_stop, CTL.xtal_pins_in, CTL.sub_osc_stop, CTL.ext_clk_ignore}, 4'hF, "osc");
    cmp({CTL.poc_en, CTL.pc_valid, CTL.lvd_en}, {2'h2, lvd}, "detectors");
    cmp(CTL.ram_keep, keep, "ram keep");
  endtask

  // wait for the run pulse and check the start state
  task automatic wait_run();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(posedge MCLK);
      #1;
      seen = (PC_LOAD === 1'b1);
    end
    cmp(seen, 1'b1, "no run");
    cmp(PC_VALUE, 16'hB2A1, "pc value");
    cmp({CTL.sys_rst, CTL.pc_valid, CTL.ihs_clk_sel, PINS_HIZ}, 4'h6, "run state");
    cmp(INIT, 56'h00_FFFF_FF00_8710, "init values");
  endtask

  // one source held for a while (the all-ones opcode for one cycle only), checked, released
  task automatic pulse(input int src, input logic lvd, input logic keep);
    @(posedge MCLK);
    drv(src, 1'b1);
    @(posedge MCLK);
    if (src == 5) drv(5, 1'b0);
    repeat (5) @(posedge MCLK);
    #1;
    in_reset(lvd, keep);
    @(posedge MCLK);
    drv(src, 1'b0);
    wait_run();
  endtask

  task automatic t_regs();
    rdchk(RSC_OFS_CAUSE, 32'h0000_0000, "cause");
    rdchk(RSC_OFS_LEVEL, 32'h0000_000E, "level");
    rdchk(RSC_OFS_DETCTL, 32'h0000_0000, "detctl");
    rdchk(RSC_OFS_PCVAL, 32'h0000_B2A1, "pc read");
    bus(1'b1, 8'h3C, 32'h0000_00FF);
    rdchk(8'h3C, 32'h0000_0000, "unmapped");
    cmp(IND_PIN_O, 1'b0, "ind low");
    bus(1'b1, RSC_OFS_PORTCTL, 32'h0000_0001);
    repeat (2) @(posedge MCLK);
    #1;
    cmp(IND_PIN_O, 1'b1, "ind high");
    $display("test regs done");
  endtask

  task automatic t_wdog();
    bus(1'b1, RSC_OFS_LEVEL, 32'h0000_0005);
    pulse(3, 1'b0, 1'b0);
    rdchk(RSC_OFS_CAUSE, 32'h0000_0010, "wdog flag");
    rdchk(RSC_OFS_CAUSE, 32'h0000_0000, "read clear");
    rdchk(RSC_OFS_LEVEL, 32'h0000_000E, "level reset");
    cmp(IND_PIN_O, 1'b0, "ind after");
    $display("test watchdog done");
  endtask

  task automatic t_lvd();
    pulse(5, 1'b0, 1'b0);
    bus(1'b1, RSC_OFS_LEVEL, 32'h0000_0005);
    pulse(2, 1'b1, 1'b0);
    rdchk(RSC_OFS_CAUSE, 32'h0000_0081, "trap lvd flags");
    rdchk(RSC_OFS_LEVEL, 32'h0000_0005, "level held");
    rdchk(RSC_OFS_CAUSE, 32'h0000_0000, "read clear");
    $display("test undervoltage done");
  endtask

  task automatic t_merge();
    @(posedge MCLK);
    drv(3, 1'b1);
    drv(4, 1'b1);
    repeat (4) @(posedge MCLK);
    drv(3, 1'b0);
    repeat (8) @(posedge MCLK);
    #1;
    cmp(CTL.sys_rst, 1'b1, "held by last");
    @(posedge MCLK);
    drv(4, 1'b0);
    wait_run();
    rdchk(RSC_OFS_CAUSE, 32'h0000_0012, "both flags");
    OPT_LVD_ON <= 1'b1;
    pulse(5, 1'b0, 1'b0);
    pulse(0, 1'b0, 1'b0);
    rdchk(RSC_OFS_CAUSE, 32'h0000_0000, "pin clears");
    rdchk(RSC_OFS_DETCTL, 32'h0000_0080, "detctl option");
    OPT_LVD_ON <= 1'b0;
    $display("test merge done");
  endtask

  task automatic t_standby();
    STANDBY <= 1'b1;
    pulse(3, 1'b0, 1'b1);
    rdchk(RSC_OFS_STATUS, 32'h0000_0002, "status keep");
    pulse(1, 1'b0, 1'b0);
    rdchk(RSC_OFS_CAUSE, 32'h0000_0000, "poc clears");
    STANDBY <= 1'b0;
    $display("test standby done");
  endtask

  // verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge MCLK);
    errors++;
    $display("FAIL %0t timeout", $time);
    finish_test();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge MCLK);
    #1;
    in_reset(1'b0, 1'b0);
    cmp(INIT, 56'h00_FFFF_FF00_8710, "init in reset");
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    wait_run();
    t_regs();
    t_wdog();
    t_lvd();
    t_merge();
    t_standby();
    finish_test();
  end
endmodule
`default_nettype wire
